//--- logic/dma_map.svh
`ifndef DMA_MAP_SVH
`define DMA_MAP_SVH

// Slave register index on the four low address inputs
`define DMA_IDX_MODE 4'h8
`define DMA_IDX_CHAN_LIMIT 4'h8
`define DMA_IDX_CHAN_MSB 2
`define DMA_IDX_CHAN_LSB 1
`define DMA_IDX_COUNT_BIT 0

// Mode register fields
`define DMA_MODE_EN_MSB 3
`define DMA_MODE_ROT_BIT 4
`define DMA_MODE_RESET 8'h00

// Count register fields
`define DMA_TYPE_MSB 15
`define DMA_TYPE_LSB 14
`define DMA_CNT_MSB 13
`define DMA_REG_RESET 16'h0000

// Write buffer entry layout and shape
`define DMA_FE_ADDR_MSB 12
`define DMA_FE_ADDR_LSB 9
`define DMA_FE_HI_BIT 8
`define DMA_FE_DATA_MSB 7
`define DMA_FIFO_WIDTH 13
`define DMA_FIFO_DEPTH 4

`endif

//--- logic/dma_pkg.sv
package dma_pkg;
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_HOLD = 5'h02,
        ST_ADDR = 5'h04,
        ST_XFER = 5'h08,
        ST_DONE = 5'h10
    } cycle_state_t;

    typedef enum logic [1:0] {
        OP_VERIFY = 2'h0,
        OP_WRITE = 2'h1,
        OP_READ = 2'h2,
        OP_ILLEGAL = 2'h3
    } op_type_t;
endpackage

//--- logic/write_fifo.sv
module write_fifo #(
    parameter int WIDTH = 13,
    parameter int DEPTH = 4
) (
    input wire logic core_clk, // System clock
    input wire logic nrst, // Sync reset, low
    input wire logic clkEn, // Freezes state when low
    input wire logic inValid, // Push request
    output logic inReady, // Room for a push
    input wire logic [WIDTH-1:0] inData, // Pushed word
    output logic outValid, // Word available
    input wire logic outReady, // Pop request
    output logic [WIDTH-1:0] outData // Oldest word
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [WIDTH-1:0] mem_nxt [DEPTH];
    logic [AW-1:0] wrPtr_r, wrPtr_nxt, rdPtr_r, rdPtr_nxt;
    logic [AW:0] count_r, count_nxt;
    logic push, pop;

    assign inReady = count_r != (AW+1)'(DEPTH);
    assign outValid = count_r != '0;
    assign outData = mem_r[rdPtr_r];
    assign push = inValid && inReady;
    assign pop = outValid && outReady;

    always_comb begin
        mem_nxt = mem_r;
        wrPtr_nxt = wrPtr_r;
        rdPtr_nxt = rdPtr_r;
        count_nxt = count_r;
        if (push) begin
            mem_nxt[wrPtr_r] = inData;
            wrPtr_nxt = (wrPtr_r == AW'(DEPTH - 1)) ? '0 : wrPtr_r + AW'(1);
        end
        if (pop) begin
            rdPtr_nxt = (rdPtr_r == AW'(DEPTH - 1)) ? '0 : rdPtr_r + AW'(1);
        end
        if (push && !pop) begin
            count_nxt = count_r + (AW+1)'(1);
        end else if (pop && !push) begin
            count_nxt = count_r - (AW+1)'(1);
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_r[i] <= '0;
            end
            wrPtr_r <= '0;
            rdPtr_r <= '0;
            count_r <= '0;
        end else if (clkEn) begin
            mem_r <= mem_nxt;
            wrPtr_r <= wrPtr_nxt;
            rdPtr_r <= rdPtr_nxt;
            count_r <= count_nxt;
        end
    end
endmodule // write_fifo

//--- logic/priority_arbiter.sv
module priority_arbiter (
    input wire logic core_clk, // System clock
    input wire logic nrst, // Sync reset, low
    input wire logic clkEn, // Freezes state when low
    input wire logic [3:0] req, // Enabled requests
    input wire logic rotate, // Rotating priority on
    input wire logic advance, // A cycle ends now
    input wire logic [1:0] servedChan, // Channel just serviced
    output logic anyReq, // Some request pending
    output logic [1:0] winner // Highest priority requester
);
    logic [1:0] highest_r, highest_nxt, idx;
    logic found;

    always_comb begin
        highest_nxt = highest_r;
        idx = 2'h0;
        found = 1'b0;
        if (rotate && advance) begin
            highest_nxt = servedChan + 2'h1;
        end
        if (!rotate) begin
            highest_nxt = 2'h0;
        end
        anyReq = |req;
        winner = highest_nxt;
        for (int i = 0; i < 4; i++) begin
            idx = highest_nxt + 2'(i);
            if (req[idx] && !found) begin
                winner = idx;
                found = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            highest_r <= 2'h0;
        end else if (clkEn) begin
            highest_r <= highest_nxt;
        end
    end
endmodule // priority_arbiter

//--- logic/dma_controller.sv
`include "dma_map.svh"
module dma_controller (
    input wire logic core_clk, // 250 MHz system clock
    input wire logic nrst, // Sync reset, low
    input wire logic clkEn, // Freezes all state when low
    input wire logic [3:0] channelRequest, // Peripheral requests
    output logic [3:0] channelAcknowledge_n, // Per-channel select, low
    output logic busHoldRequest, // Asks the CPU for the bus
    input wire logic busHoldGrant, // CPU has released the bus
    input wire logic memReady, // Low adds wait states
    input wire logic chipSelect_n, // Slave select, low
    input wire logic [3:0] addrIn, // Register select in slave mode
    output logic [7:0] addrOut, // Low memory address byte
    output logic addrOe, // Drives address pins
    input wire logic [7:0] dataIn, // Data bus input
    output logic [7:0] dataOut, // Data bus output
    output logic dataOe, // Drives data bus
    input wire logic periphReadIn_n, // Slave register read, low
    input wire logic periphWriteIn_n, // Slave register write, low
    output logic periphReadStrobe_n, // Master peripheral read, low
    output logic periphWriteStrobe_n, // Master peripheral write, low
    output logic memoryReadStrobe_n, // Memory read, low
    output logic memoryWriteStrobe_n, // Memory write, low
    output logic controlOe, // Drives the four strobes
    output logic upperAddressStrobe, // Latches high address byte
    output logic masterBusIsolate, // High while master
    output logic blockEndFlag, // Last cycle of the block
    output logic regWriteReady // Room for a register write
);
    dma_pkg::cycle_state_t state_r, state_nxt;
    dma_pkg::op_type_t curOp;
    logic [15:0] addr_r [4];
    logic [15:0] addr_nxt [4];
    logic [15:0] cnt_r [4];
    logic [15:0] cnt_nxt [4];
    logic [7:0] mode_r, mode_nxt;
    logic [3:0] tcSeen_r, tcSeen_nxt;
    logic [1:0] cur_r, cur_nxt;
    logic [7:0] addrOut_r, addrOut_nxt, dataOut_r, dataOut_nxt;
    logic blockEnd_r, blockEnd_nxt;
    logic ptrHigh_r, ptrHigh_nxt;
    logic wrPrev_r, rdPrev_r;
    logic slave, wrFall, rdFall, master, stAddr, stXfer, stDone;
    logic anyReq, fifoOutValid, fifoPop, statusRead, enterAddr;
    logic [1:0] winner;
    logic [3:0] enabledReq;
    logic [`DMA_FIFO_WIDTH-1:0] fifoIn, fifoOut;
    logic [3:0] feAddr;
    logic [1:0] feChan, rdChan;
    logic [7:0] feData, readByte;
    logic [15:0] rdWord;

    assign stAddr = state_r == dma_pkg::ST_ADDR;
    assign stXfer = state_r == dma_pkg::ST_XFER;
    assign stDone = state_r == dma_pkg::ST_DONE;
    assign master = stAddr || stXfer || stDone;
    assign slave = !chipSelect_n && !master;
    assign wrFall = slave && wrPrev_r && !periphWriteIn_n;
    assign rdFall = slave && rdPrev_r && !periphReadIn_n;
    assign enabledReq = channelRequest & mode_r[`DMA_MODE_EN_MSB:0];
    assign curOp = dma_pkg::op_type_t'(cnt_r[cur_r][`DMA_TYPE_MSB:`DMA_TYPE_LSB]);

    assign fifoIn = {addrIn, ptrHigh_r, dataIn};
    assign feAddr = fifoOut[`DMA_FE_ADDR_MSB:`DMA_FE_ADDR_LSB];
    assign feChan = feAddr[`DMA_IDX_CHAN_MSB:`DMA_IDX_CHAN_LSB];
    assign feData = fifoOut[`DMA_FE_DATA_MSB:0];
    // Register updates wait until the sequencer is back in ST_IDLE
    assign fifoPop = fifoOutValid && state_r == dma_pkg::ST_IDLE;

    write_fifo #(
        .WIDTH(`DMA_FIFO_WIDTH),
        .DEPTH(`DMA_FIFO_DEPTH)
    ) u_write_fifo (
        .core_clk(core_clk),
        .nrst(nrst),
        .clkEn(clkEn),
        .inValid(wrFall),
        .inReady(regWriteReady),
        .inData(fifoIn),
        .outValid(fifoOutValid),
        .outReady(fifoPop),
        .outData(fifoOut)
    );

    priority_arbiter u_priority_arbiter (
        .core_clk(core_clk),
        .nrst(nrst),
        .clkEn(clkEn),
        .req(enabledReq),
        .rotate(mode_r[`DMA_MODE_ROT_BIT]),
        .advance(stDone),
        .servedChan(cur_r),
        .anyReq(anyReq),
        .winner(winner)
    );

    assign rdChan = addrIn[`DMA_IDX_CHAN_MSB:`DMA_IDX_CHAN_LSB];
    assign rdWord = addrIn[`DMA_IDX_COUNT_BIT] ? cnt_r[rdChan] : addr_r[rdChan];
    assign statusRead = rdFall && addrIn == `DMA_IDX_MODE;
    always_comb begin
        readByte = 8'h00;
        if (addrIn < `DMA_IDX_CHAN_LIMIT) begin
            readByte = ptrHigh_r ? rdWord[15:8] : rdWord[7:0];
        end else if (addrIn == `DMA_IDX_MODE) begin
            readByte = {3'h0, master, tcSeen_r};
        end
    end

    // Register file next values
    always_comb begin
        addr_nxt = addr_r;
        cnt_nxt = cnt_r;
        mode_nxt = mode_r;
        tcSeen_nxt = tcSeen_r;
        ptrHigh_nxt = ptrHigh_r;
        if ((wrFall || rdFall) && addrIn < `DMA_IDX_CHAN_LIMIT) begin
            ptrHigh_nxt = !ptrHigh_r;
        end else if (wrFall && addrIn == `DMA_IDX_MODE) begin
            ptrHigh_nxt = 1'b0;
        end
        if (fifoPop && feAddr < `DMA_IDX_CHAN_LIMIT) begin
            if (feAddr[`DMA_IDX_COUNT_BIT]) begin
                if (fifoOut[`DMA_FE_HI_BIT]) begin
                    cnt_nxt[feChan][15:8] = feData;
                end else begin
                    cnt_nxt[feChan][7:0] = feData;
                end
            end else if (fifoOut[`DMA_FE_HI_BIT]) begin
                addr_nxt[feChan][15:8] = feData;
            end else begin
                addr_nxt[feChan][7:0] = feData;
            end
        end else if (fifoPop && feAddr == `DMA_IDX_MODE) begin
            mode_nxt = feData;
        end
        if (stDone) begin
            addr_nxt[cur_r] = addr_r[cur_r] + 16'h0001;
            cnt_nxt[cur_r][`DMA_CNT_MSB:0] =
                cnt_r[cur_r][`DMA_CNT_MSB:0] - 14'h0001;
        end
        if (statusRead) begin
            tcSeen_nxt = 4'h0;
        end
        // end of block recorded, set wins
        if (stDone && blockEnd_r) begin
            tcSeen_nxt[cur_r] = 1'b1;
        end
    end

    // Cycle sequencer next values
    always_comb begin
        state_nxt = state_r;
        cur_nxt = cur_r;
        addrOut_nxt = addrOut_r;
        dataOut_nxt = dataOut_r;
        blockEnd_nxt = blockEnd_r;
        enterAddr = 1'b0;
        if (rdFall) begin
            dataOut_nxt = readByte;
        end
        unique case (state_r)
            dma_pkg::ST_IDLE: begin
                if (anyReq) begin
                    state_nxt = dma_pkg::ST_HOLD;
                end
            end
            dma_pkg::ST_HOLD: begin
                if (!anyReq) begin
                    state_nxt = dma_pkg::ST_IDLE;
                end else if (busHoldGrant) begin
                    enterAddr = 1'b1;
                end
            end
            dma_pkg::ST_ADDR: begin
                state_nxt = dma_pkg::ST_XFER;
            end
            dma_pkg::ST_XFER: begin
                if (memReady) begin
                    state_nxt = dma_pkg::ST_DONE;
                end
            end
            dma_pkg::ST_DONE: begin
                if (anyReq && busHoldGrant) begin
                    enterAddr = 1'b1;
                end else begin
                    state_nxt = dma_pkg::ST_IDLE;
                    blockEnd_nxt = 1'b0;
                end
            end
        endcase
        if (enterAddr) begin
            state_nxt = dma_pkg::ST_ADDR;
            cur_nxt = winner;
            addrOut_nxt = addr_nxt[winner][7:0];
            dataOut_nxt = addr_nxt[winner][15:8];
            blockEnd_nxt = cnt_nxt[winner][`DMA_CNT_MSB:0] == 14'h0000;
        end
    end

    always_comb begin
        channelAcknowledge_n = 4'hf;
        if (stXfer) begin
            channelAcknowledge_n[cur_r] = 1'b0;
        end
    end

    // strobes only in the transfer state
    // read out of memory, write into it
    assign memoryReadStrobe_n = !(stXfer && curOp == dma_pkg::OP_READ);
    assign periphWriteStrobe_n = !(stXfer && curOp == dma_pkg::OP_READ);
    assign memoryWriteStrobe_n = !(stXfer && curOp == dma_pkg::OP_WRITE);
    assign periphReadStrobe_n = !(stXfer && curOp == dma_pkg::OP_WRITE);
    assign controlOe = master;
    assign addrOe = master;
    assign masterBusIsolate = master;
    assign busHoldRequest = state_r != dma_pkg::ST_IDLE;
    assign upperAddressStrobe = stAddr;
    assign dataOe = stAddr || (slave && !periphReadIn_n);
    assign addrOut = addrOut_r;
    assign dataOut = dataOut_r;
    assign blockEndFlag = blockEnd_r && master;

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            for (int i = 0; i < 4; i++) begin
                addr_r[i] <= `DMA_REG_RESET;
                cnt_r[i] <= `DMA_REG_RESET;
            end
            mode_r <= `DMA_MODE_RESET;
            tcSeen_r <= 4'h0;
            ptrHigh_r <= 1'b0;
            wrPrev_r <= 1'b1;
            rdPrev_r <= 1'b1;
            state_r <= dma_pkg::ST_IDLE;
            cur_r <= 2'h0;
            addrOut_r <= 8'h00;
            dataOut_r <= 8'h00;
            blockEnd_r <= 1'b0;
        end else if (clkEn) begin
            addr_r <= addr_nxt;
            cnt_r <= cnt_nxt;
            mode_r <= mode_nxt;
            tcSeen_r <= tcSeen_nxt;
            ptrHigh_r <= ptrHigh_nxt;
            wrPrev_r <= periphWriteIn_n;
            rdPrev_r <= periphReadIn_n;
            state_r <= state_nxt;
            cur_r <= cur_nxt;
            addrOut_r <= addrOut_nxt;
            dataOut_r <= dataOut_nxt;
            blockEnd_r <= blockEnd_nxt;
        end
    end
endmodule // dma_controller

//--- tb/dma_controller_checker.sv
module dma_controller_checker (
    input wire logic core_clk, // System clock
    input wire logic nrst, // Sync reset, low
    input wire logic [3:0] channelAcknowledge_n, // Acks, low
    input wire logic busHoldRequest, // Hold request
    input wire logic busHoldGrant, // Hold grant
    input wire logic memReady, // Wait control
    input wire logic addrOe, // Address drive
    input wire logic dataOe, // Data drive
    input wire logic periphReadStrobe_n, // Strobe, low
    input wire logic periphWriteStrobe_n, // Strobe, low
    input wire logic memoryReadStrobe_n, // Strobe, low
    input wire logic memoryWriteStrobe_n, // Strobe, low
    input wire logic controlOe, // Strobe drive
    input wire logic upperAddressStrobe, // High byte latch
    input wire logic masterBusIsolate // Master flag
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!nrst);

    hold_first_a: assert property (channelAcknowledge_n != 4'hf |->
        busHoldRequest && masterBusIsolate) else $error("ack off bus");
    grant_seen_a: assert property (upperAddressStrobe |->
        $past(busHoldGrant)) else $error("cycle without grant");
    one_ack_a: assert property ($onehot0(~channelAcknowledge_n))
        else $error("several acks");
    ack_after_addr_a: assert property ($fell(&channelAcknowledge_n)
        |-> $past(upperAddressStrobe)) else $error("ack without addr");
    ack_release_a: assert property (channelAcknowledge_n != 4'hf
        && memReady |=> channelAcknowledge_n == 4'hf)
        else $error("ack held");
    strobe_in_xfer_a: assert property (!(periphReadStrobe_n
        && periphWriteStrobe_n && memoryReadStrobe_n && memoryWriteStrobe_n)
        |-> channelAcknowledge_n != 4'hf && controlOe)
        else $error("stray strobe");
    strobe_pairs_a: assert property (controlOe |->
        periphReadStrobe_n == memoryWriteStrobe_n
        && periphWriteStrobe_n == memoryReadStrobe_n
        && (periphReadStrobe_n || periphWriteStrobe_n))
        else $error("bad strobe pair");
    upper_byte_a: assert property (upperAddressStrobe |-> dataOe
        && addrOe ##1 !dataOe && !upperAddressStrobe)
        else $error("data bus not released");
    reset_quiet_a: assert property ($rose(nrst) |-> !busHoldRequest
        && !controlOe && !addrOe && channelAcknowledge_n == 4'hf)
        else $error("outputs active at reset");
endmodule // dma_controller_checker

bind dma_controller dma_controller_checker chk_u (
    .core_clk(core_clk), .nrst(nrst), .memReady(memReady),
    .channelAcknowledge_n(channelAcknowledge_n),
    .busHoldRequest(busHoldRequest), .busHoldGrant(busHoldGrant),
    .addrOe(addrOe), .dataOe(dataOe), .controlOe(controlOe),
    .periphReadStrobe_n(periphReadStrobe_n),
    .periphWriteStrobe_n(periphWriteStrobe_n),
    .memoryReadStrobe_n(memoryReadStrobe_n),
    .memoryWriteStrobe_n(memoryWriteStrobe_n),
    .upperAddressStrobe(upperAddressStrobe),
    .masterBusIsolate(masterBusIsolate)
);

//--- tb/dma_far_side.sv
module dma_far_side (
    input wire logic core_clk, // System clock
    input wire logic nrst, // Sync reset, low
    input wire logic busHoldRequest, // Hold asked
    input wire logic grantOn, // Grant allowed
    input wire logic [3:0] channelAcknowledge_n, // Acks, low
    input wire logic [3:0] startMask, // Load byte budgets
    input wire logic [7:0] startBytes, // Budget per channel
    output logic busHoldGrant, // Bus released
    output logic [3:0] channelRequest // Requests
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] left_r [4];
    logic [3:0] ackPrev_r;

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            busHoldGrant <= 1'b0;
            ackPrev_r <= 4'hf;
            for (int i = 0; i < 4; i++)
                left_r[i] <= 8'h00;
        end else begin
            busHoldGrant <= busHoldRequest && grantOn;
            ackPrev_r <= channelAcknowledge_n;
            for (int i = 0; i < 4; i++) begin
                if (startMask[i])
                    left_r[i] <= startBytes;
                else if (!channelAcknowledge_n[i] && ackPrev_r[i]
                    && left_r[i] != 8'h00)
                    left_r[i] <= left_r[i] - 8'h01;
            end
        end
    end

    always_comb begin
        for (int i = 0; i < 4; i++)
            channelRequest[i] = left_r[i] != 8'h00;
    end
endmodule // dma_far_side

//--- tb/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic core_clk;
    logic nrst;
    logic chipSelect_n;
    logic memReady = 1'b1;
    logic clkEn = 1'b1;
    logic isolate;
    logic periphReadIn_n;
    logic periphWriteIn_n;
    logic grantOn;
    logic stallOn;
    logic busHoldGrant;
    logic busHoldRequest;
    logic holdPrev;
    logic controlOe;
    logic upperAddressStrobe;
    logic blockEndFlag;
    logic regWriteReady;
    logic tcCap;
    logic [3:0] channelRequest;
    logic [3:0] channelAcknowledge_n;
    logic [3:0] ackPrev = 4'hf;
    logic [3:0] strb;
    logic [3:0] addrIn;
    logic [3:0] startMask;
    logic [7:0] startBytes;
    logic [7:0] dataIn;
    logic [7:0] dataOut;
    logic [7:0] addrOut;
    logic [15:0] addrCap;
    logic [15:0] v;
    logic [24:0] recs[$];
    int error_cnt;
    int comparisons;
    int holdRises;
    int h0;
    int cyc;

    dma_controller dut_u (
        .core_clk(core_clk), .nrst(nrst), .clkEn(clkEn),
        .channelRequest(channelRequest),
        .channelAcknowledge_n(channelAcknowledge_n),
        .busHoldRequest(busHoldRequest), .busHoldGrant(busHoldGrant),
        .memReady(memReady), .chipSelect_n(chipSelect_n),
        .addrIn(addrIn), .addrOut(addrOut), .addrOe(),
        .dataIn(dataIn), .dataOut(dataOut), .dataOe(),
        .periphReadIn_n(periphReadIn_n), .periphWriteIn_n(periphWriteIn_n),
        .periphReadStrobe_n(strb[3]), .periphWriteStrobe_n(strb[2]),
        .memoryReadStrobe_n(strb[1]), .memoryWriteStrobe_n(strb[0]),
        .controlOe(controlOe), .upperAddressStrobe(upperAddressStrobe),
        .masterBusIsolate(isolate), .blockEndFlag(blockEndFlag),
        .regWriteReady(regWriteReady)
    );

    dma_far_side peer_u (
        .core_clk(core_clk), .nrst(nrst), .busHoldRequest(busHoldRequest),
        .grantOn(grantOn), .channelAcknowledge_n(channelAcknowledge_n),
        .startMask(startMask), .startBytes(startBytes),
        .busHoldGrant(busHoldGrant), .channelRequest(channelRequest)
    );

    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    // One record per byte at the first ack cycle
    always @(negedge core_clk) begin
        if (upperAddressStrobe) begin
            addrCap = {dataOut, addrOut};
            tcCap = blockEndFlag;
        end
        if (ackPrev == 4'hf && channelAcknowledge_n != 4'hf) begin
            recs.push_back({channelAcknowledge_n, strb, tcCap, addrCap});
            check("isolate", isolate, 1'b1);
        end
        if (busHoldRequest && !holdPrev)
            holdRises++;
        holdPrev = busHoldRequest;
        ackPrev = channelAcknowledge_n;
        memReady = !(stallOn && cyc % 3 == 0);
        cyc++;
    end

    task automatic results();
        $display("Comparisons %0d, errors %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(logic [3:0] idx, logic [7:0] val);
        @(negedge core_clk);
        chipSelect_n = 1'b0;
        addrIn = idx;
        dataIn = val;
        periphWriteIn_n = 1'b0;
        @(negedge core_clk);
        periphWriteIn_n = 1'b1;
        chipSelect_n = 1'b1;
    endtask

    task automatic rd(logic [3:0] idx, output logic [7:0] val);
        @(negedge core_clk);
        chipSelect_n = 1'b0;
        addrIn = idx;
        periphReadIn_n = 1'b0;
        repeat (2) @(negedge core_clk);
        val = dataOut;
        periphReadIn_n = 1'b1;
        chipSelect_n = 1'b1;
    endtask

    task automatic rd16(logic [3:0] idx, output logic [15:0] val);
        rd(idx, val[7:0]);
        rd(idx, val[15:8]);
    endtask

    task automatic prog(logic [1:0] ch, logic [15:0] a, logic [15:0] n);
        wr({1'b0, ch, 1'b0}, a[7:0]);
        wr({1'b0, ch, 1'b0}, a[15:8]);
        wr({1'b0, ch, 1'b1}, n[7:0]);
        wr({1'b0, ch, 1'b1}, n[15:8]);
    endtask

    task automatic start(logic [3:0] m, logic [7:0] n);
        @(negedge core_clk);
        startMask = m;
        startBytes = n;
        @(negedge core_clk);
        startMask = 4'h0;
    endtask

    task automatic settle();
        for (int i = 0; i < 400; i++) begin
            @(negedge core_clk);
            if (channelRequest == 4'h0 && !busHoldRequest)
                return;
        end
        error_cnt++;
        results();
    endtask

    task automatic xfer(logic [1:0] ch, logic [15:0] a, logic [1:0] t,
        logic tc);
        logic [3:0] s;
        logic [24:0] r;
        s = t == 2'b01 ? 4'b0110 : t == 2'b10 ? 4'b1001 : 4'b1111;
        r = recs.size() > 0 ? recs.pop_front() : 'x;
        check("xfer", 32'(r), 32'({~(4'h1 << ch), s, tc, a}));
    endtask

    initial begin
        nrst = 1'b0;
        chipSelect_n = 1'b1;
        periphReadIn_n = 1'b1;
        periphWriteIn_n = 1'b1;
        addrIn = 4'h0;
        dataIn = 8'h00;
        grantOn = 1'b0;
        stallOn = 1'b0;
        startMask = 4'h0;
        startBytes = 8'h00;
        repeat (12) @(negedge core_clk);
        nrst = 1'b1;
        check("quiet", {busHoldRequest, controlOe, channelAcknowledge_n},
            6'h0f);
        check("wready", regWriteReady, 1'b1);
        check("isolate idle", isolate, 1'b0);
        rd16(4'h0, v);
        check("addr0 reset", 32'(v), 32'h0000_0000);
        prog(2'd0, 16'h12fe, 16'h4001);
        wr(4'h8, 8'h01);
        start(4'h1, 8'h02);
        repeat (2) @(negedge core_clk);
        check("hold", busHoldRequest, 1'b1);
        check("no ack", channelAcknowledge_n, 4'hf);
        prog(2'd1, 16'h2000, 16'h8000);
        check("buffer full", regWriteReady, 1'b0);
        grantOn = 1'b1;
        settle();
        prog(2'd2, 16'h3000, 16'h0000);
        prog(2'd3, 16'h40ff, 16'hc000);
        wr(4'h8, 8'h0f);
        stallOn = 1'b1;
        start(4'hf, 8'h01);
        settle();
        stallOn = 1'b0;
        xfer(2'd0, 16'h12fe, 2'b01, 1'b0);
        xfer(2'd0, 16'h12ff, 2'b01, 1'b1);
        xfer(2'd0, 16'h1300, 2'b01, 1'b0);
        xfer(2'd1, 16'h2000, 2'b10, 1'b1);
        xfer(2'd2, 16'h3000, 2'b00, 1'b1);
        xfer(2'd3, 16'h40ff, 2'b11, 1'b1);
        rd16(4'h3, v);
        check("count1", 32'(v), 32'h0000_bfff);
        rd16(4'h2, v);
        check("addr1", 32'(v), 32'h0000_2001);
        rd16(4'h0, v);
        check("addr0", 32'(v), 32'h0000_1301);
        rd(4'h8, v[7:0]);
        check("status", 32'(v[7:0]), 32'h0000_000f);
        rd(4'h8, v[7:0]);
        check("status clr", 32'(v[7:0]), 32'h0000_0000);
        wr(4'h8, 8'h00);
        for (int c = 0; c < 4; c++)
            prog(2'(c), 16'h5000 + 16'(c * 16), 16'h4001);
        wr(4'h8, 8'h1f);
        h0 = holdRises;
        start(4'hf, 8'h02);
        settle();
        check("one hold", 32'(holdRises - h0), 32'h0000_0001);
        for (int k = 0; k < 8; k++)
            xfer(2'(k % 4), 16'h5000 + 16'(k % 4 * 16 + k / 4), 2'b01,
                1'(k / 4));
        // Frozen core ignores the request
        clkEn = 1'b0;
        start(4'h1, 8'h01);
        repeat (3) @(negedge core_clk);
        check("frozen", busHoldRequest, 1'b0);
        clkEn = 1'b1;
        settle();
        xfer(2'd0, 16'h5002, 2'b01, 1'b0);
        check("extra", 32'(recs.size()), 32'h0000_0000);
        results();
    end
endmodule // testbench
